// File: logic/status_regs_defines.svh
/*
 Offsets, field positions and reset values of the status and result bank.
 Assumes it is included by bare name into the design file.
*/
`ifndef STATUS_REGS_DEFINES_SVH
`define STATUS_REGS_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_ERROR_FLAGS        8'h0a
`define OFS_COLLISION_INDEX    8'h0b
`define OFS_COUNTER_NOW        8'h0c
`define OFS_CHECKSUM_LOW       8'h0d
`define OFS_CHECKSUM_HIGH      8'h0e

// ----------------------------------------
// Error flag bit positions
// ----------------------------------------
`define BIT_KEY_FORMAT_ERROR   6
`define BIT_NVM_RIGHTS_ERROR   5
`define BIT_QUEUE_OVERFLOW     4
`define BIT_CHECKSUM_ERROR     3
`define BIT_FRAME_START_ERROR  2
`define BIT_PARITY_FAIL        1
`define BIT_COLLISION          0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ERROR_FLAGS        8'h40
`define RST_COLLISION_INDEX    8'h00
`define RST_QUEUE_LEVEL        8'h00

`endif

// File: logic/status_regs_pkg.sv
/*
 Types shared by the status and result bank.
 Assumes the defines header sits beside it.
*/
package status_regs_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [1:0] {
        CHECKSUM_8,
        CHECKSUM_16
    } checksum_mode_e;

endpackage : status_regs_pkg

// File: logic/rf_reader_status_regs.sv
/*
 Read-only status and result registers of a contactless reader: error flags,
 first collision position, live timer count, checksum result bytes, plus the
 queue level that the overflow flag and the queue clear act upon.
 Assumes all event inputs are one-cycle pulses from logic on CLK.
*/
`timescale 1ns/1ps
`include "status_regs_defines.svh"

module rf_reader_status_regs
    import status_regs_pkg::*;
#(
    parameter int QUEUE_DEPTH = 64
) (
    input  wire logic                   CLK,
    input  wire logic                   RESET,
    input  wire logic [7:0]             ADDR,
    input  wire logic [7:0]             WDATA,
    input  wire logic                   WR,
    input  wire logic                   RD,
    output logic [7:0]                  RDATA,
    input  wire logic                   KEY_LOAD_START,
    input  wire logic                   KEY_FORMAT_BAD,
    input  wire logic                   NVM_CMD_START,
    input  wire logic                   NVM_RIGHTS_VIOLATION,
    input  wire logic                   QUEUE_WRITE,
    input  wire logic                   QUEUE_READ,
    input  wire logic                   QUEUE_CLEAR,
    input  wire logic                   RECEIVE_PREPARE,
    input  wire logic                   RX_CHECKSUM_CHECK_ENABLE,
    input  wire logic                   CHECKSUM_FAIL,
    input  wire logic                   FRAME_START_BAD,
    input  wire logic                   PARITY_BAD,
    input  wire logic                   COLLISION_SEEN,
    input  wire logic [7:0]             COLLISION_POS,
    input  wire logic                   TIMER_LOAD,
    input  wire logic [7:0]             TIMER_RELOAD,
    input  wire logic                   TIMER_TICK,
    input  wire logic [15:0]            CHECKSUM_VALUE,
    input  wire status_regs_pkg::checksum_mode_e CHECKSUM_MODE,
    input  wire logic                   CHECKSUM_READY,
    output logic [7:0]                  QUEUE_LEVEL,
    output logic                        QUEUE_FULL,
    output logic                        COUNTER_EXPIRED_IRQ
);
    import status_regs_pkg::*;

    // ----------------------------------------
    // Error flags
    // ----------------------------------------
    logic [6:0] error_flags;
    logic       queue_full_now;
    logic       overflow_event;
    logic       first_collision;
    logic       collision_taken;

    assign queue_full_now = QUEUE_FULL;
    // Overflow raised only when no clear lands the same cycle; clear empties the queue
    assign overflow_event = QUEUE_WRITE && queue_full_now && !QUEUE_CLEAR;

    // Set wins over clear for every flag except the overflow flag, where a queue clear in the same cycle wins
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            error_flags <= 7'(`RST_ERROR_FLAGS);
        end else begin
            if (KEY_FORMAT_BAD)
                error_flags[`BIT_KEY_FORMAT_ERROR] <= 1'b1;
            else if (KEY_LOAD_START)
                error_flags[`BIT_KEY_FORMAT_ERROR] <= 1'b0;
            if (NVM_RIGHTS_VIOLATION)
                error_flags[`BIT_NVM_RIGHTS_ERROR] <= 1'b1;
            else if (NVM_CMD_START)
                error_flags[`BIT_NVM_RIGHTS_ERROR] <= 1'b0;
            if (overflow_event)
                error_flags[`BIT_QUEUE_OVERFLOW] <= 1'b1;
            else if (QUEUE_CLEAR)
                error_flags[`BIT_QUEUE_OVERFLOW] <= 1'b0;
            if (RX_CHECKSUM_CHECK_ENABLE && CHECKSUM_FAIL)
                error_flags[`BIT_CHECKSUM_ERROR] <= 1'b1;
            else if (RECEIVE_PREPARE)
                error_flags[`BIT_CHECKSUM_ERROR] <= 1'b0;
            if (FRAME_START_BAD)
                error_flags[`BIT_FRAME_START_ERROR] <= 1'b1;
            else if (RECEIVE_PREPARE)
                error_flags[`BIT_FRAME_START_ERROR] <= 1'b0;
            if (PARITY_BAD)
                error_flags[`BIT_PARITY_FAIL] <= 1'b1;
            else if (RECEIVE_PREPARE)
                error_flags[`BIT_PARITY_FAIL] <= 1'b0;
            if (COLLISION_SEEN)
                error_flags[`BIT_COLLISION] <= 1'b1;
            else if (RECEIVE_PREPARE)
                error_flags[`BIT_COLLISION] <= 1'b0;
        end
    end

    // ----------------------------------------
    // First collision position
    // ----------------------------------------
    logic [7:0] collision_bit_index;

    // Later collisions in the same frame are ignored until the next preparation
    assign first_collision = COLLISION_SEEN && !collision_taken;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            collision_taken     <= 1'b0;
            collision_bit_index <= `RST_COLLISION_INDEX;
        end else begin
            if (first_collision) begin
                collision_taken     <= 1'b1;
                collision_bit_index <= COLLISION_POS;
            end else if (RECEIVE_PREPARE) begin
                collision_taken <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Timer counter
    // ----------------------------------------
    // Count is cleared here only to keep simulation free of unknowns
    logic [7:0] counter_now;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            counter_now <= 8'h00;
        end else if (TIMER_LOAD) begin
            counter_now <= TIMER_RELOAD;
        end else if (TIMER_TICK && counter_now != 8'h00) begin
            counter_now <= counter_now - 8'h01;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            COUNTER_EXPIRED_IRQ <= 1'b0;
        else
            COUNTER_EXPIRED_IRQ <= !TIMER_LOAD && TIMER_TICK && counter_now == 8'h01;
    end

    // ----------------------------------------
    // Queue level
    // ----------------------------------------
    // Full is a flop fed from the next level, so the pin never glitches
    logic [7:0] next_queue_level;

    always_comb begin
        next_queue_level = QUEUE_LEVEL;
        if (QUEUE_CLEAR) begin
            next_queue_level = `RST_QUEUE_LEVEL;
        end else begin
            case ({QUEUE_WRITE && !queue_full_now, QUEUE_READ && QUEUE_LEVEL != 8'h00})
                2'b10:   next_queue_level = QUEUE_LEVEL + 8'h01;
                2'b01:   next_queue_level = QUEUE_LEVEL - 8'h01;
                default: next_queue_level = QUEUE_LEVEL;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            QUEUE_LEVEL <= `RST_QUEUE_LEVEL;
        else
            QUEUE_LEVEL <= next_queue_level;
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            QUEUE_FULL <= 1'b0;
        else
            QUEUE_FULL <= ({24'h0, next_queue_level} == QUEUE_DEPTH);
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // WR is never decoded: these registers are read-only
    byte_t next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        unique case (ADDR)
            `OFS_ERROR_FLAGS:     next_rdata = {1'b0, error_flags};
            `OFS_COLLISION_INDEX: next_rdata = collision_bit_index;
            `OFS_COUNTER_NOW:     next_rdata = counter_now;
            `OFS_CHECKSUM_LOW:    next_rdata = CHECKSUM_VALUE[7:0];
            `OFS_CHECKSUM_HIGH:   next_rdata = (CHECKSUM_MODE == CHECKSUM_16) ?
                                               CHECKSUM_VALUE[15:8] : 8'h00;
            default:              next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            RDATA <= 8'h00;
        else if (RD)
            RDATA <= next_rdata;
        else
            RDATA <= 8'h00;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_prepare_clean;
        RECEIVE_PREPARE && !COLLISION_SEEN && !PARITY_BAD && !FRAME_START_BAD && !CHECKSUM_FAIL;
    endsequence

    sequence s_tick_to_zero;
        TIMER_TICK && !TIMER_LOAD && counter_now == 8'h01;
    endsequence

    sequence s_first_capture;
        first_collision ##1 (!RECEIVE_PREPARE)[*3];
    endsequence

    a_key_error_set: assert property (@(posedge CLK) disable iff (RESET)
        KEY_FORMAT_BAD |=> error_flags[`BIT_KEY_FORMAT_ERROR])
        else $error("key error not set");
    a_key_error_clear: assert property (@(posedge CLK) disable iff (RESET)
        KEY_LOAD_START && !KEY_FORMAT_BAD |=> !error_flags[`BIT_KEY_FORMAT_ERROR])
        else $error("key error not cleared");
    a_nvm_error_track: assert property (@(posedge CLK) disable iff (RESET)
        NVM_RIGHTS_VIOLATION |=> error_flags[`BIT_NVM_RIGHTS_ERROR])
        else $error("rights error not set");
    a_nvm_error_clear: assert property (@(posedge CLK) disable iff (RESET)
        NVM_CMD_START && !NVM_RIGHTS_VIOLATION |=> !error_flags[`BIT_NVM_RIGHTS_ERROR])
        else $error("rights error not cleared");
    a_overflow_set: assert property (@(posedge CLK) disable iff (RESET)
        QUEUE_WRITE && QUEUE_FULL && !QUEUE_CLEAR |=> error_flags[`BIT_QUEUE_OVERFLOW])
        else $error("overflow not flagged");
    a_queue_clear: assert property (@(posedge CLK) disable iff (RESET)
        QUEUE_CLEAR |=> QUEUE_LEVEL == 8'h00 && !error_flags[`BIT_QUEUE_OVERFLOW])
        else $error("queue clear failed");
    a_checksum_gate: assert property (@(posedge CLK) disable iff (RESET)
        CHECKSUM_FAIL && !RX_CHECKSUM_CHECK_ENABLE && !error_flags[`BIT_CHECKSUM_ERROR] |=> !error_flags[3])
        else $error("checksum error while disabled");
    a_prepare_clears: assert property (@(posedge CLK) disable iff (RESET)
        s_prepare_clean |=> error_flags[3:0] == 4'h0)
        else $error("receive flags not cleared");
    a_first_collision: assert property (@(posedge CLK) disable iff (RESET)
        s_first_capture |=> collision_bit_index == $past(COLLISION_POS, 4))
        else $error("collision index lost");
    a_timer_expiry: assert property (@(posedge CLK) disable iff (RESET)
        s_tick_to_zero |=> counter_now == 8'h00 && COUNTER_EXPIRED_IRQ)
        else $error("expiry not raised");
    a_read_latency: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == `OFS_CHECKSUM_LOW |=> RDATA == $past(CHECKSUM_VALUE[7:0]))
        else $error("low result mismatch");
    a_write_ignored: assert property (@(posedge CLK) disable iff (RESET)
        WR && !KEY_FORMAT_BAD && !KEY_LOAD_START && !NVM_RIGHTS_VIOLATION && !NVM_CMD_START
        && !QUEUE_WRITE && !QUEUE_CLEAR && !RECEIVE_PREPARE && !CHECKSUM_FAIL && !FRAME_START_BAD
        && !PARITY_BAD && !COLLISION_SEEN |=> $stable(error_flags))
        else $error("write altered flags");


    // ----------------------------------------
    // Checks: flag retention
    // ----------------------------------------
    a_key_error_holds: assert property (@(posedge CLK) disable iff (RESET)
        !KEY_FORMAT_BAD && !KEY_LOAD_START |=> $stable(error_flags[`BIT_KEY_FORMAT_ERROR]))
        else $error("key error moved");
    a_nvm_error_holds: assert property (@(posedge CLK) disable iff (RESET)
        !NVM_RIGHTS_VIOLATION && !NVM_CMD_START |=> $stable(error_flags[`BIT_NVM_RIGHTS_ERROR]))
        else $error("rights error moved");
    a_overflow_holds: assert property (@(posedge CLK) disable iff (RESET)
        !(QUEUE_WRITE && QUEUE_FULL) && !QUEUE_CLEAR |=> $stable(error_flags[`BIT_QUEUE_OVERFLOW]))
        else $error("overflow flag moved");
    a_receive_flags_hold: assert property (@(posedge CLK) disable iff (RESET)
        !RECEIVE_PREPARE |=> (error_flags[3:0] & $past(error_flags[3:0])) == $past(error_flags[3:0]))
        else $error("receive flag dropped");

    // ----------------------------------------
    // Checks: receive error setting
    // ----------------------------------------
    a_checksum_set: assert property (@(posedge CLK) disable iff (RESET)
        RX_CHECKSUM_CHECK_ENABLE && CHECKSUM_FAIL |=> error_flags[`BIT_CHECKSUM_ERROR])
        else $error("checksum error not set");
    a_frame_error_set: assert property (@(posedge CLK) disable iff (RESET)
        FRAME_START_BAD |=> error_flags[`BIT_FRAME_START_ERROR])
        else $error("framing error not set");
    a_parity_error_set: assert property (@(posedge CLK) disable iff (RESET)
        PARITY_BAD |=> error_flags[`BIT_PARITY_FAIL])
        else $error("parity error not set");
    a_collision_flag_set: assert property (@(posedge CLK) disable iff (RESET)
        COLLISION_SEEN |=> error_flags[`BIT_COLLISION])
        else $error("collision flag not set");

    // ----------------------------------------
    // Checks: collision capture
    // ----------------------------------------
    a_collision_capture: assert property (@(posedge CLK) disable iff (RESET)
        first_collision |=> collision_bit_index == $past(COLLISION_POS) && collision_taken)
        else $error("collision position not taken");
    a_collision_locked: assert property (@(posedge CLK) disable iff (RESET)
        collision_taken && !RECEIVE_PREPARE |=> $stable(collision_bit_index))
        else $error("later collision overwrote index");
    a_prepare_rearms: assert property (@(posedge CLK) disable iff (RESET)
        RECEIVE_PREPARE && !first_collision |=> !collision_taken)
        else $error("capture not rearmed");

    // ----------------------------------------
    // Checks: timer
    // ----------------------------------------
    a_timer_load: assert property (@(posedge CLK) disable iff (RESET)
        TIMER_LOAD |=> counter_now == $past(TIMER_RELOAD))
        else $error("timer load lost");
    a_timer_tick: assert property (@(posedge CLK) disable iff (RESET)
        TIMER_TICK && !TIMER_LOAD && counter_now != 8'h00 |=> counter_now == $past(counter_now) - 8'h01)
        else $error("timer tick lost");
    a_timer_idle: assert property (@(posedge CLK) disable iff (RESET)
        !TIMER_TICK && !TIMER_LOAD |=> $stable(counter_now))
        else $error("timer moved while idle");
    a_expiry_at_zero: assert property (@(posedge CLK) disable iff (RESET)
        COUNTER_EXPIRED_IRQ |-> counter_now == 8'h00)
        else $error("expiry with count above zero");
    a_expiry_pulse: assert property (@(posedge CLK) disable iff (RESET)
        COUNTER_EXPIRED_IRQ |=> !COUNTER_EXPIRED_IRQ)
        else $error("expiry longer than one cycle");

    // ----------------------------------------
    // Checks: queue
    // ----------------------------------------
    a_full_matches: assert property (@(posedge CLK) disable iff (RESET)
        QUEUE_FULL == ({24'h0, QUEUE_LEVEL} == QUEUE_DEPTH))
        else $error("full flag disagrees with level");
    a_level_bound: assert property (@(posedge CLK) disable iff (RESET)
        {24'h0, QUEUE_LEVEL} <= QUEUE_DEPTH)
        else $error("queue level above depth");
    a_full_kept: assert property (@(posedge CLK) disable iff (RESET)
        QUEUE_WRITE && QUEUE_FULL && !QUEUE_READ && !QUEUE_CLEAR |=> QUEUE_FULL)
        else $error("write into full queue changed level");

    // ----------------------------------------
    // Checks: read port
    // ----------------------------------------
    a_error_read: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == `OFS_ERROR_FLAGS |=> RDATA == {1'b0, $past(error_flags)})
        else $error("flag read mismatch");
    a_reserved_zero: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == `OFS_ERROR_FLAGS |=> !RDATA[7])
        else $error("reserved bit set");
    a_index_read: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == `OFS_COLLISION_INDEX |=> RDATA == $past(collision_bit_index))
        else $error("index read mismatch");
    a_counter_read: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == `OFS_COUNTER_NOW |=> RDATA == $past(counter_now))
        else $error("count read mismatch");
    a_low_ready: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == `OFS_CHECKSUM_LOW && CHECKSUM_READY |=> RDATA == $past(CHECKSUM_VALUE[7:0]))
        else $error("valid low result mismatch");
    a_high_read: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == `OFS_CHECKSUM_HIGH && CHECKSUM_MODE == CHECKSUM_16 |=> RDATA == $past(CHECKSUM_VALUE[15:8]))
        else $error("high result mismatch");
    a_high_eight_bit: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == `OFS_CHECKSUM_HIGH && CHECKSUM_MODE == CHECKSUM_8 |=> RDATA == 8'h00)
        else $error("high result not zero in short mode");
    a_unmapped_zero: assert property (@(posedge CLK) disable iff (RESET)
        RD && (ADDR < `OFS_ERROR_FLAGS || ADDR > `OFS_CHECKSUM_HIGH) |=> RDATA == 8'h00)
        else $error("unmapped read not zero");

endmodule : rf_reader_status_regs

// File: dv/status_host.sv
/*
 Host model: drives the plain register port with one-cycle strobes.
 Assumes the bank answers a read in the cycle after the strobe.
*/
`timescale 1ns/1ps

module status_host (
    input  wire logic       CLK,
    input  wire logic [7:0] RDATA,
    output logic      [7:0] ADDR,
    output logic      [7:0] WDATA,
    output logic            WR,
    output logic            RD
);
    initial begin
        ADDR  = 8'h00;
        WDATA = 8'h00;
        WR    = 1'b0;
        RD    = 1'b0;
    end

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // Read data stand for one cycle only, so they are taken just after that edge
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask : rd

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= v;
        WR    <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr
endmodule : status_host

// File: dv/rf_reader_status_regs_tb.sv
/*
 Self-checking bench of the status and result bank.
 Assumes the design and the host model are compiled before it.
*/
`timescale 1ns/1ps

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end

module rf_reader_status_regs_tb;
    import status_regs_pkg::*;

    // ----------------------------------------
    // Stimulus and wiring
    // ----------------------------------------
    logic [7:0]     addr, wdata, rdata, cpos, reload, level, d;
    logic [15:0]    csum;
    logic [13:0]    ev;
    logic           clk, reset, wr, rd, chk_en, cready, full, irq;
    checksum_mode_e cmode;
    int             failures, total_checks, irqs;

    initial begin
        clk = 0; reset = 1; ev = '0; chk_en = 0; cpos = 8'h00; reload = 8'h00;
        csum = 16'hbeef; cmode = CHECKSUM_16; cready = 1; failures = 0; total_checks = 0; irqs = 0;
    end
    always #5 clk = ~clk;
    always @(posedge clk) if (irq === 1'b1) irqs++;

    status_host i_host (.CLK(clk), .RDATA(rdata), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd));

    // Event bits: 0 key start, 1 key bad, 2 nvm start, 3 nvm violation, 4 queue write, 5 queue read,
    // 6 queue clear, 7 prepare, 8 checksum fail, 9 frame bad, 10 parity, 11 collision, 12 load, 13 tick
    rf_reader_status_regs #(.QUEUE_DEPTH(4)) i_dut (
        .CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .KEY_LOAD_START(ev[0]), .KEY_FORMAT_BAD(ev[1]), .NVM_CMD_START(ev[2]),
        .NVM_RIGHTS_VIOLATION(ev[3]), .QUEUE_WRITE(ev[4]), .QUEUE_READ(ev[5]), .QUEUE_CLEAR(ev[6]),
        .RECEIVE_PREPARE(ev[7]), .RX_CHECKSUM_CHECK_ENABLE(chk_en), .CHECKSUM_FAIL(ev[8]),
        .FRAME_START_BAD(ev[9]), .PARITY_BAD(ev[10]), .COLLISION_SEEN(ev[11]), .COLLISION_POS(cpos),
        .TIMER_LOAD(ev[12]), .TIMER_RELOAD(reload), .TIMER_TICK(ev[13]), .CHECKSUM_VALUE(csum),
        .CHECKSUM_MODE(cmode), .CHECKSUM_READY(cready), .QUEUE_LEVEL(level), .QUEUE_FULL(full),
        .COUNTER_EXPIRED_IRQ(irq));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task pulse(input int b);
        @(posedge clk);
        ev[b] <= 1'b1;
        @(posedge clk);
        ev <= '0;
    endtask : pulse

    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, d);
        `CHK(d, e)
    endtask : rd_chk

    task report_and_stop;
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    initial begin
        #100000;
        failures++;
        report_and_stop();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rd_chk(8'h0a, 8'h40);
        rd_chk(8'h0b, 8'h00);
        pulse(0); rd_chk(8'h0a, 8'h00);
        pulse(1); rd_chk(8'h0a, 8'h40);
        pulse(3); rd_chk(8'h0a, 8'h60);
        pulse(2); rd_chk(8'h0a, 8'h40);
        // Frame with every receive error and two collisions; only the first position is kept
        chk_en <= 1'b1; cpos <= 8'h05;
        for (int b = 8; b <= 11; b++) pulse(b);
        cpos <= 8'h02; pulse(11);
        rd_chk(8'h0a, 8'h4f);
        rd_chk(8'h0b, 8'h05);
        pulse(7); rd_chk(8'h0a, 8'h40);
        cpos <= 8'h08; pulse(11); rd_chk(8'h0b, 8'h08);
        pulse(7); chk_en <= 1'b0; pulse(8);
        rd_chk(8'h0a, 8'h40);
        // Queue filled to the brim, then one write too many
        for (int i = 0; i < 4; i++) pulse(4);
        #1 `CHK(full, 1'b1)
        rd_chk(8'h0a, 8'h40);
        pulse(4); rd_chk(8'h0a, 8'h50);
        pulse(5); #1 `CHK(level, 8'h03)
        pulse(6); #1 `CHK(level, 8'h00)
        rd_chk(8'h0a, 8'h40);
        // Timer runs down to zero; a further tick must not expire it again
        reload <= 8'h03; pulse(12); rd_chk(8'h0c, 8'h03);
        for (int i = 0; i < 3; i++) pulse(13);
        rd_chk(8'h0c, 8'h00);
        pulse(13); rd_chk(8'h0c, 8'h00);
        `CHK(irqs, 1)
        rd_chk(8'h0d, 8'hef);
        rd_chk(8'h0e, 8'hbe);
        cmode <= CHECKSUM_8; rd_chk(8'h0e, 8'h00);
        // Writes everywhere, then nothing may have moved
        for (int a = 10; a <= 14; a++) i_host.wr(a[7:0], 8'hff);
        rd_chk(8'h0a, 8'h40);
        rd_chk(8'h0b, 8'h08);
        rd_chk(8'h0d, 8'hef);
        rd_chk(8'h0f, 8'h00);
        report_and_stop();
    end
endmodule : rf_reader_status_regs_tb
